// ### hfcc_consts.vh
/*
 Constants of the package feedback configuration and notification block:
 register addresses, bit positions, reset value and structure layout.
 Assumes it is included by bare name from each design file.
*/
`ifndef HFCC_CONSTS_VH
`define HFCC_CONSTS_VH
// =====================================================================
// Register addresses
`define HFCC_CFG_ADDR    32'h000017D1
`define HFCC_STAT_ADDR   32'h000017E0
`define HFCC_IRQ_ADDR    32'h000017E1
// =====================================================================
// Field positions, reset value and configuration values
`define HFCC_CFG_EN      0
`define HFCC_CFG_MC      1
`define HFCC_STAT_BIT    26
`define HFCC_IRQEN_BIT   25
`define HFCC_CFG_RESET   2'h0
`define HFCC_CFG_BASE    2'h1
`define HFCC_CFG_BOTH    2'h3
// =====================================================================
// Structure layout and writer operations
`define HFCC_HDR_BYTES   8
`define HFCC_CHG_MARK    8'h01
`define HFCC_CHG_CLEAR   8'h00
`define HFCC_OP_POP      2'h0
`define HFCC_OP_UPD      2'h1
`define HFCC_OP_CLR      2'h2
`endif

// ### hfcc_feedback_ctl.v
/*
 Package feedback configuration and notification control: configuration,
 status and interrupt-enable registers on the register access port,
 transition decoding, structure population and change notification.
 Assumes register requests, capability data and update requests come from
 logic on ref_clk; the structure pointer is held elsewhere.
*/
`timescale 1ns/100ps
`include "hfcc_consts.vh"
module hfcc_feedback_ctl
#(
    parameter NUM_LP    = 4,
    parameter NUM_CLASS = 4,
    parameter ADDR_W    = 12
)
(
    input  wire              ref_clk,
    input  wire              rstn,
    input  wire              mcSupported,
    input  wire              msrReq,
    input  wire              msrWrite,
    input  wire [31:0]       msrAddr,
    input  wire [63:0]       msrWrData,
    output reg               msrAck,
    output reg  [63:0]       msrRdData,
    output reg               msrFault,
    input  wire              capUpdateReq,
    output wire [ADDR_W-1:0] capAddr,
    input  wire [7:0]        capData,
    output wire              memWrEn,
    output wire [ADDR_W-1:0] memWrAddr,
    output wire [7:0]        memWrData,
    output reg               thermIrq,
    output reg               feedbackOn,
    output reg               multiClassOn
);

// =====================================================================
// Reset release
reg rstMeta;
reg rstSyncN;

always @(posedge ref_clk or negedge rstn)
begin
    if (!rstn)
    begin
        rstMeta  <= 1'b0;
        rstSyncN <= 1'b0;
    end
    else
    begin
        rstMeta  <= 1'b1;
        rstSyncN <= rstMeta;
    end
end

// =====================================================================
// State
reg [1:0] cfg;
reg       statusBit;
reg       irqEn;
reg       popPend;
reg       updPend;
reg       clrPend;
reg       ackEvt;
reg       initEvt;
reg       wrStart;
reg [1:0] wrOp;
reg [1:0] curOp;

wire      wrBusy;
wire      wrDone;

// =====================================================================
// Register decode
wire cfgHit  = (msrAddr == `HFCC_CFG_ADDR);
wire statHit = (msrAddr == `HFCC_STAT_ADDR);
wire irqHit  = (msrAddr == `HFCC_IRQ_ADDR);
wire anyHit  = cfgHit | statHit | irqHit;

wire wrCfg   = msrReq & msrWrite & cfgHit;
wire wrStat  = msrReq & msrWrite & statHit;
wire wrIrq   = msrReq & msrWrite & irqHit;

// Multi-class without enumerated support faults and leaves cfg untouched
wire mcFault = wrCfg & msrWrData[`HFCC_CFG_MC] & ~mcSupported;
wire cfgTake = wrCfg & ~mcFault;

// Multi-class without base enable is stored as fully off; reserved bits dropped
wire [1:0] newCfg = {msrWrData[`HFCC_CFG_MC] & msrWrData[`HFCC_CFG_EN],
                     msrWrData[`HFCC_CFG_EN]};

// Unchanged value and dropping only multi-class are silent
wire cfgQuiet = (newCfg == cfg) |
                ((cfg == `HFCC_CFG_BOTH) & (newCfg == `HFCC_CFG_BASE));
wire cfgAct   = cfgTake & ~cfgQuiet;
wire enAct    = cfgAct & newCfg[`HFCC_CFG_EN];
wire disAct   = cfgAct & ~newCfg[`HFCC_CFG_EN];

wire statClr  = wrStat & ~msrWrData[`HFCC_STAT_BIT];
wire irqRise  = wrIrq & msrWrData[`HFCC_IRQEN_BIT] & ~irqEn;

// =====================================================================
// Status events
wire updDone = wrDone & (curOp != `HFCC_OP_CLR);
wire setEvt  = ackEvt | initEvt | updDone;

// Any restart or disable halts a walk in progress
wire wrAbort = enAct | disAct;

// =====================================================================
// Configuration register
always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        cfg <= `HFCC_CFG_RESET;
    end
    else if (cfgTake)
    begin
        cfg <= newCfg;
    end
end

// =====================================================================
// Status and interrupt enable
always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        statusBit <= 1'b0;
        irqEn     <= 1'b0;
        ackEvt    <= 1'b0;
        initEvt   <= 1'b0;
    end
    else
    begin
        ackEvt  <= disAct;
        initEvt <= irqRise;
        if (wrIrq)
        begin
            irqEn <= msrWrData[`HFCC_IRQEN_BIT];
        end
        // Set wins over a clear in the same cycle; writing one does nothing
        if (setEvt)
        begin
            statusBit <= 1'b1;
        end
        else if (statClr)
        begin
            statusBit <= 1'b0;
        end
    end
end

// =====================================================================
// Pending work
always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        popPend <= 1'b0;
        updPend <= 1'b0;
        clrPend <= 1'b0;
    end
    else if (disAct)
    begin
        // No structure writes once disabled
        popPend <= 1'b0;
        updPend <= 1'b0;
        clrPend <= 1'b0;
    end
    else
    begin
        if (enAct)
        begin
            popPend <= 1'b1;
        end
        else if (wrStart & (wrOp == `HFCC_OP_POP))
        begin
            popPend <= 1'b0;
        end

        if (capUpdateReq & cfg[`HFCC_CFG_EN])
        begin
            updPend <= 1'b1;
        end
        else if (wrStart & (wrOp == `HFCC_OP_UPD))
        begin
            updPend <= 1'b0;
        end

        if (statClr & statusBit & ~setEvt & cfg[`HFCC_CFG_EN])
        begin
            clrPend <= 1'b1;
        end
        else if (wrStart & (wrOp == `HFCC_OP_CLR))
        begin
            clrPend <= 1'b0;
        end
    end
end

// =====================================================================
// Walk scheduler
reg       next_wrStart;
reg [1:0] next_wrOp;

always @*
begin
    next_wrStart = 1'b0;
    next_wrOp    = `HFCC_OP_POP;
    if (cfg[`HFCC_CFG_EN] & ~wrBusy & ~wrStart & ~wrAbort)
    begin
        if (popPend)
        begin
            next_wrStart = 1'b1;
            next_wrOp    = `HFCC_OP_POP;
        end
        else if (clrPend & ~statusBit)
        begin
            next_wrStart = 1'b1;
            next_wrOp    = `HFCC_OP_CLR;
        end
        else if (updPend & ~statusBit)
        begin
            next_wrStart = 1'b1;
            next_wrOp    = `HFCC_OP_UPD;
        end
    end
end

always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        wrStart <= 1'b0;
        wrOp    <= `HFCC_OP_POP;
        curOp   <= `HFCC_OP_POP;
    end
    else
    begin
        wrStart <= next_wrStart;
        wrOp    <= next_wrOp;
        if (wrStart)
        begin
            curOp <= wrOp;
        end
    end
end

// =====================================================================
// Structure writer
hfcc_struct_writer
#(
    .NUM_LP    (NUM_LP),
    .NUM_CLASS (NUM_CLASS),
    .ADDR_W    (ADDR_W)
)
uWriter
(
    .clk        (ref_clk),
    .rstSyncN   (rstSyncN),
    .start      (wrStart & ~wrAbort),
    .abort      (wrAbort),
    .cellsOn    (wrOp != `HFCC_OP_CLR),
    .multiClass (cfg[`HFCC_CFG_MC]),
    .chgValue   ((wrOp == `HFCC_OP_UPD) ? `HFCC_CHG_MARK : `HFCC_CHG_CLEAR),
    .capData    (capData),
    .capAddr    (capAddr),
    .busy       (wrBusy),
    .done       (wrDone),
    .memWrEn    (memWrEn),
    .memWrAddr  (memWrAddr),
    .memWrData  (memWrData)
);

// =====================================================================
// Interrupt and status outputs
always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        thermIrq     <= 1'b0;
        feedbackOn   <= 1'b0;
        multiClassOn <= 1'b0;
    end
    else
    begin
        thermIrq     <= setEvt & irqEn;
        feedbackOn   <= cfg[`HFCC_CFG_EN];
        multiClassOn <= cfg[`HFCC_CFG_MC];
    end
end

// =====================================================================
// Register access answer
reg [63:0] next_rdData;

always @*
begin
    next_rdData = 64'h0000000000000000;
    if (cfgHit)
    begin
        next_rdData[1:0] = cfg;
    end
    else if (statHit)
    begin
        next_rdData[`HFCC_STAT_BIT] = statusBit;
    end
    else if (irqHit)
    begin
        next_rdData[`HFCC_IRQEN_BIT] = irqEn;
    end
end

always @(posedge ref_clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        msrAck    <= 1'b0;
        msrRdData <= 64'h0000000000000000;
        msrFault  <= 1'b0;
    end
    else
    begin
        msrAck   <= msrReq;
        msrFault <= msrReq & (~anyHit | mcFault);
        if (msrReq & ~msrWrite)
        begin
            msrRdData <= next_rdData;
        end
    end
end

endmodule

// ### hfcc_feedback_ctl_sva.sv
/*
 Port checker of the feedback control block.
 Assumes it is bound to hfcc_feedback_ctl, everything on ref_clk.
*/
`timescale 1ns/100ps
module hfcc_feedback_ctl_sva
(
    input wire        ref_clk,
    input wire        rstn,
    input wire        mcSupported,
    input wire        msrReq,
    input wire        msrWrite,
    input wire [31:0] msrAddr,
    input wire [63:0] msrWrData,
    input wire        msrAck,
    input wire [63:0] msrRdData,
    input wire        msrFault,
    input wire        memWrEn,
    input wire        thermIrq,
    input wire        feedbackOn,
    input wire        multiClassOn
);
    // =====================================================================
    // Mirror of the interrupt enable
    reg  irqEnM;
    wire cfgWr = msrReq && msrWrite && msrAddr == 32'h000017D1;
    wire cfgRd = msrReq && !msrWrite && msrAddr == 32'h000017D1;
    wire ienWr = msrReq && msrWrite && msrAddr == 32'h000017E1;
    always @(posedge ref_clk or negedge rstn)
        if (!rstn)
            irqEnM <= 1'b0;
        else if (ienWr)
            irqEnM <= msrWrData[25];
    // =====================================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence sIenRise;
        ienWr && msrWrData[25] && !irqEnM;
    endsequence
    sequence sNotify;
        ##2 thermIrq;
    endsequence
    sequence sQuiet;
        (!thermIrq && !memWrEn) [*4];
    endsequence
    AST_ACK: assert property (msrReq |=> msrAck)
        else $error("no acknowledge after request");
    AST_CFG_WRITE: assert property (cfgWr && (mcSupported || !msrWrData[1]) |-> ##2
        feedbackOn == $past(msrWrData[0], 2) &&
        multiClassOn == ($past(msrWrData[1], 2) && $past(msrWrData[0], 2)))
        else $error("enable copies differ from written value");
    AST_MC_FAULT: assert property (cfgWr && msrWrData[1] && !mcSupported |=>
        msrFault ##1 $stable(feedbackOn) && $stable(multiClassOn))
        else $error("unsupported multi-class write not refused");
    AST_MC_NEEDS_BASE: assert property (multiClassOn |-> feedbackOn)
        else $error("multi-class on without base enable");
    AST_RSVD_ZERO: assert property (cfgRd |=> msrRdData[63:2] == 62'h0)
        else $error("reserved configuration bits read nonzero");
    AST_IEN_NOTIFY: assert property (sIenRise |-> sNotify)
        else $error("no initial notification on enable rise");
    AST_IRQ_GATED: assert property (thermIrq |-> irqEnM || $past(irqEnM))
        else $error("interrupt while interrupt enable is off");
    AST_DIS_ACK: assert property ($fell(feedbackOn) && irqEnM |-> thermIrq)
        else $error("no interrupt acknowledging disable");
    AST_OFF_QUIET: assert property (!feedbackOn [*3] |-> !memWrEn)
        else $error("structure write while disabled");
    AST_SILENT_OFF: assert property (cfgWr && !feedbackOn && !msrWrData[0] |=> sQuiet)
        else $error("activity after a quiet transition");
    AST_MC_DROP: assert property (cfgWr && multiClassOn && msrWrData[1:0] == 2'h1 |=> sQuiet)
        else $error("activity after dropping multi-class");
endmodule
bind hfcc_feedback_ctl hfcc_feedback_ctl_sva u_sva
(
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .mcSupported  (mcSupported),
    .msrReq       (msrReq),
    .msrWrite     (msrWrite),
    .msrAddr      (msrAddr),
    .msrWrData    (msrWrData),
    .msrAck       (msrAck),
    .msrRdData    (msrRdData),
    .msrFault     (msrFault),
    .memWrEn      (memWrEn),
    .thermIrq     (thermIrq),
    .feedbackOn   (feedbackOn),
    .multiClassOn (multiClassOn)
);

// ### hfcc_struct_writer.v
/*
 Walks the feedback structure in memory: change indication bytes first,
 then capability cells if cellsOn was set at start. Assumes capability data answer capAddr in the
 same cycle from logic on the same clock.
*/
`timescale 1ns/100ps
`include "hfcc_consts.vh"
module hfcc_struct_writer
#(
    parameter NUM_LP    = 4,
    parameter NUM_CLASS = 4,
    parameter ADDR_W    = 12
)
(
    input  wire              clk,
    input  wire              rstSyncN,
    input  wire              start,
    input  wire              abort,
    input  wire              cellsOn,
    input  wire              multiClass,
    input  wire [7:0]        chgValue,
    input  wire [7:0]        capData,
    output wire [ADDR_W-1:0] capAddr,
    output reg               busy,
    output reg               done,
    output reg               memWrEn,
    output reg  [ADDR_W-1:0] memWrAddr,
    output reg  [7:0]        memWrData
);
localparam [1:0]        ST_IDLE   = 2'h0;
localparam [1:0]        ST_HDR    = 2'h1;
localparam [1:0]        ST_CELL   = 2'h2;
localparam integer      CELL_TOP  = NUM_LP * NUM_CLASS * 2 - 1;
localparam integer      CLS_TOP   = NUM_CLASS - 1;
localparam integer      HDR_TOP   = `HFCC_HDR_BYTES;
localparam integer      ONE_I     = 1;
localparam [ADDR_W-1:0] LAST_CELL = CELL_TOP[ADDR_W-1:0];
localparam [ADDR_W-1:0] LAST_CLS  = CLS_TOP[ADDR_W-1:0];
localparam [ADDR_W-1:0] HDR_OFS   = HDR_TOP[ADDR_W-1:0];
localparam [ADDR_W-1:0] ONE       = ONE_I[ADDR_W-1:0];

reg [1:0]        state;
reg [ADDR_W-1:0] idx;
reg [ADDR_W-1:0] cls;
reg              kind;
reg              cells;
reg [7:0]        chg;

assign capAddr = idx;

always @(posedge clk or negedge rstSyncN)
begin
    if (!rstSyncN)
    begin
        state     <= ST_IDLE;
        idx       <= {ADDR_W{1'b0}};
        cls       <= {ADDR_W{1'b0}};
        kind      <= 1'b0;
        cells     <= 1'b0;
        chg       <= 8'h00;
        busy      <= 1'b0;
        done      <= 1'b0;
        memWrEn   <= 1'b0;
        memWrAddr <= {ADDR_W{1'b0}};
        memWrData <= 8'h00;
    end
    else
    begin
        done    <= 1'b0;
        memWrEn <= 1'b0;
        if (abort)
        begin
            state <= ST_IDLE;
            busy  <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= ST_HDR;
                        busy  <= 1'b1;
                        idx   <= {ADDR_W{1'b0}};
                        cells <= cellsOn;
                        chg   <= chgValue;
                    end
                end
                ST_HDR:
                begin
                    memWrEn   <= 1'b1;
                    memWrAddr <= idx;
                    memWrData <= chg;
                    idx       <= idx + ONE;
                    if (idx == LAST_CLS)
                    begin
                        idx  <= {ADDR_W{1'b0}};
                        cls  <= {ADDR_W{1'b0}};
                        kind <= 1'b0;
                        if (cells)
                        begin
                            state <= ST_CELL;
                        end
                        else
                        begin
                            state <= ST_IDLE;
                            busy  <= 1'b0;
                            done  <= 1'b1;
                        end
                    end
                end
                ST_CELL:
                begin
                    // Class 0 columns always, others only in multi-class
                    memWrEn   <= multiClass | (cls == {ADDR_W{1'b0}});
                    memWrAddr <= HDR_OFS + idx;
                    memWrData <= capData;
                    idx       <= idx + ONE;
                    kind      <= ~kind;
                    if (kind)
                    begin
                        cls <= (cls == LAST_CLS) ? {ADDR_W{1'b0}} : cls + ONE;
                    end
                    if (idx == LAST_CELL)
                    begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end
end

endmodule

// ### tb_top.sv
/*
 Self-checking bench of the feedback control block: register accesses
 with expected values. Assumes the constants header and the checker.
*/
`timescale 1ns/100ps
`include "hfcc_consts.vh"
module tb_top;
    localparam LPS = 4;
    localparam CLS = 4;
    reg         ref_clk      = 1'b0;
    reg         rstn         = 1'b0;
    reg         mcSupported  = 1'b0;
    reg         msrReq       = 1'b0;
    reg         msrWrite     = 1'b0;
    reg  [31:0] msrAddr      = 32'h0;
    reg  [63:0] msrWrData    = 64'h0;
    reg         capUpdateReq = 1'b0;
    wire        msrAck;
    wire [63:0] msrRdData;
    wire        msrFault;
    wire [11:0] capAddr;
    wire [7:0]  capData      = capAddr[7:0] ^ 8'h5A;
    wire        memWrEn;
    wire [11:0] memWrAddr;
    wire [7:0]  memWrData;
    wire        thermIrq;
    wire        feedbackOn;
    wire        multiClassOn;
    reg  [63:0] rd;
    integer     bad_count    = 0;
    integer     checked      = 0;
    integer     cycles       = 0;
    integer     hdrW, hdrSet, cellW, irqN;
    integer     cellBad      = 0;
    reg  [11:0] cellOfs;
    hfcc_feedback_ctl #(.NUM_LP(LPS), .NUM_CLASS(CLS), .ADDR_W(12)) dut
    (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .mcSupported  (mcSupported),
        .msrReq       (msrReq),
        .msrWrite     (msrWrite),
        .msrAddr      (msrAddr),
        .msrWrData    (msrWrData),
        .msrAck       (msrAck),
        .msrRdData    (msrRdData),
        .msrFault     (msrFault),
        .capUpdateReq (capUpdateReq),
        .capAddr      (capAddr),
        .capData      (capData),
        .memWrEn      (memWrEn),
        .memWrAddr    (memWrAddr),
        .memWrData    (memWrData),
        .thermIrq     (thermIrq),
        .feedbackOn   (feedbackOn),
        .multiClassOn (multiClassOn)
    );
    always #12.5 ref_clk = ~ref_clk;
    // =====================================================================
    // Tasks
    task stop_test;
    begin
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task check(input string name, input [63:0] seen, input [63:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // One access; answer sampled in the cycle after the taking edge
    task acc(input w, input [31:0] a, input [63:0] d, input ef);
    begin
        @(posedge ref_clk);
        msrReq    <= 1'b1;
        msrWrite  <= w;
        msrAddr   <= a;
        msrWrData <= d;
        @(posedge ref_clk);
        msrReq <= 1'b0;
        #1;
        check("ack", msrAck, 64'h1);
        check("fault", msrFault, ef);
        rd = msrRdData;
    end
    endtask
    task waitSt;
        integer n;
    begin
        n  = 0;
        rd = 64'h0;
        while (rd[26] !== 1'b1 && n < 80)
        begin
            acc(1'b0, `HFCC_STAT_ADDR, 64'h0, 1'b0);
            n = n + 1;
        end
        check("status", rd[26], 64'h1);
        repeat (4) @(posedge ref_clk);
    end
    endtask
    task clrMon;
    begin
        hdrW   = 0;
        hdrSet = 0;
        cellW  = 0;
        irqN   = 0;
    end
    endtask
    task updPulse;
    begin
        @(posedge ref_clk);
        capUpdateReq <= 1'b1;
        @(posedge ref_clk);
        capUpdateReq <= 1'b0;
    end
    endtask
    // =====================================================================
    // Structure write and interrupt counters, hang limit
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (memWrEn && memWrAddr < 12'h008)
        begin
            hdrW = hdrW + 1;
            if (memWrData !== 8'h00)
                hdrSet = hdrSet + 1;
        end
        if (memWrEn && memWrAddr >= 12'h008)
        begin
            cellW   = cellW + 1;
            cellOfs = memWrAddr - 12'h008;
            if (memWrData !== (cellOfs[7:0] ^ 8'h5A))
                cellBad = cellBad + 1;
        end
        if (thermIrq)
            irqN = irqN + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
    // =====================================================================
    // Scenarios
    initial
    begin
        clrMon;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(1'b0, `HFCC_CFG_ADDR, 64'h0, 1'b0);
        check("cfg reset", rd, 64'h0);
        acc(1'b0, 32'h000017D5, 64'h0, 1'b1);
        check("unmapped", rd, 64'h0);
        acc(1'b1, `HFCC_IRQ_ADDR, 64'h0000000002000000, 1'b0);
        waitSt;
        check("notify irq", irqN, 64'h1);
        acc(1'b0, `HFCC_IRQ_ADDR, 64'h0, 1'b0);
        check("irq enable", rd, 64'h0000000002000000);
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0000000004000000, 1'b0);
        acc(1'b0, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        check("status set by write", rd[26], 64'h0);
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'hFFFFFFFFFFFFFFFD, 1'b0);
        waitSt;
        check("class0 cells", cellW, 2 * LPS);
        check("headers", hdrW, CLS);
        check("enable irq", irqN, 64'h1);
        acc(1'b0, `HFCC_CFG_ADDR, 64'h0, 1'b0);
        check("cfg reserved", rd, 64'h1);
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        repeat (12) @(posedge ref_clk);
        acc(1'b1, `HFCC_CFG_ADDR, 64'h3, 1'b1);
        acc(1'b0, `HFCC_CFG_ADDR, 64'h0, 1'b0);
        check("cfg after fault", rd, 64'h1);
        mcSupported <= 1'b1;
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'h3, 1'b0);
        waitSt;
        check("all cells", cellW, 2 * LPS * CLS);
        check("mc on", multiClassOn, 64'h1);
        check("multi irq", irqN, 64'h1);
        clrMon;
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        repeat (12) @(posedge ref_clk);
        check("change cleared", hdrW, CLS);
        check("change nonzero", hdrSet, 64'h0);
        clrMon;
        updPulse;
        waitSt;
        check("change marked", hdrSet, CLS);
        check("update cells", cellW, 2 * LPS * CLS);
        check("update irq", irqN, 64'h1);
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        repeat (12) @(posedge ref_clk);
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'h1, 1'b0);
        repeat (10) @(posedge ref_clk);
        acc(1'b0, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        check("drop status", rd[26], 64'h0);
        check("drop activity", irqN + hdrW + cellW, 64'h0);
        check("base kept", feedbackOn, 64'h1);
        check("mc off", multiClassOn, 64'h0);
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'h0, 1'b0);
        waitSt;
        check("disable irq", irqN, 64'h1);
        check("disable writes", hdrW + cellW, 64'h0);
        acc(1'b1, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        repeat (6) @(posedge ref_clk);
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'h2, 1'b0);
        repeat (10) @(posedge ref_clk);
        acc(1'b0, `HFCC_CFG_ADDR, 64'h0, 1'b0);
        check("mc without base", rd, 64'h0);
        acc(1'b0, `HFCC_STAT_ADDR, 64'h0, 1'b0);
        check("ignored status", rd[26] + irqN, 64'h0);
        acc(1'b1, `HFCC_IRQ_ADDR, 64'h0, 1'b0);
        clrMon;
        acc(1'b1, `HFCC_CFG_ADDR, 64'h1, 1'b0);
        waitSt;
        check("masked irq", irqN, 64'h0);
        clrMon;
        updPulse;
        repeat (20) @(posedge ref_clk);
        check("held update", hdrW + cellW, 64'h0);
        check("cell data", cellBad, 64'h0);
        stop_test;
    end
endmodule
